// ---- src/twx_pkg.sv ----
// Purpose: Shared constants for the 12-bit instruction execute subset.
// Assumes: One instruction cycle is four i_clk periods.
// Notes:   Opcode patterns, field positions and reset values live here.
package twx_pkg;

	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 5;
	localparam int          PC_W          = 11;
	localparam int          INSTR_W       = 12;
	localparam int          FILE_DEPTH    = 32;

	// Phase counter, four clock periods per instruction cycle
	localparam logic [1:0]  PH_FETCH      = 2'h0;
	localparam logic [1:0]  PH_EXEC       = 2'h2;
	localparam logic [1:0]  PH_LAST       = 2'h3;

	// Field positions inside the instruction word
	localparam int          DEST_BIT      = 5;
	localparam int          OP6_LSB       = 6;
	localparam int          OP4_LSB       = 8;
	localparam int          DIRECTION_LOAD_OP_SEL_W    = 3;

	// Opcode patterns
	localparam logic [5:0]  OP6_ROT_RIGHT = 6'h0C;
	localparam logic [5:0]  OP6_ROT_LEFT  = 6'h0D;
	localparam logic [5:0]  OP6_SWAP      = 6'h0E;
	localparam logic [5:0]  OP6_XOR_FILE  = 6'h06;
	localparam logic [5:0]  OP6_SUB       = 6'h02;
	localparam logic [3:0]  OP4_RET_LIT   = 4'h8;
	localparam logic [3:0]  OP4_XOR_LIT   = 4'hF;
	localparam logic [11:0] OP_SLEEP      = 12'h003;
	localparam logic [8:0]  OP9_DIRECTION_LOAD_OP      = 9'h000;
	localparam logic [2:0]  DIRECTION_LOAD_OP_SEL_B    = 3'h6;
	localparam logic [2:0]  DIRECTION_LOAD_OP_SEL_C    = 3'h7;

	// Values after reset
	localparam logic [7:0]  RST_W         = 8'h00;
	localparam logic [7:0]  RST_DIR       = 8'hFF;
	localparam logic [11:0] RST_INSTR     = 12'h000;
	localparam logic [10:0] RST_PC        = 11'h000;

	typedef enum logic [1:0] {
		TWX_ST_RUN   = 2'b00,
		TWX_ST_FLUSH = 2'b01,
		TWX_ST_SLEEP = 2'b10
	} twx_state_t;

endpackage

// ---- src/twx_fr_if.sv ----
// Purpose: Carries file register accesses between executor and storage.
// Assumes: Read data appear one clock after the address.
// Notes:   Write and read share one address.
interface twx_fr_if;
	import twx_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic              wr_en;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	modport ctrl (output addr, output wr_en, output wdata, input rdata);
	modport mem  (input addr, input wr_en, input wdata, output rdata);
endinterface

// ---- src/twx_file_mem.sv ----
// Purpose: 32 by 8 file register storage with registered read data.
// Assumes: Single clock, no reset on contents.
// Notes:   A write and read of one address return the old value.
module twx_file_mem
	import twx_pkg::*;
(
	input wire logic i_clk,
	twx_fr_if.mem    fr
);
	logic [DATA_W-1:0] mem [FILE_DEPTH];
	logic [DATA_W-1:0] rdata_q;

	always_ff @(posedge i_clk) begin
		if (fr.wr_en) begin
			mem[fr.addr] <= fr.wdata;
		end
		rdata_q <= mem[fr.addr];
	end

	assign fr.rdata = rdata_q;
endmodule

// ---- src/twx_exec.sv ----
// Purpose: Decode and execute a subset of the 12-bit instruction set.
// Assumes: i_instr is stable at the clock edge ending phase 0.
// Notes:   Opcodes outside the subset execute as one-cycle no-ops.
module twx_exec
	import twx_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic [INSTR_W-1:0] i_instr,
	input  wire logic [PC_W-1:0]    i_stack_top,
	input  wire logic               i_wake_pin,
	output logic                    o_cycle_strobe,
	output logic [DATA_W-1:0]       o_w,
	output logic                    o_pc_load,
	output logic [PC_W-1:0]         o_pc_value,
	output logic                    o_carry,
	output logic                    o_digit_carry_flag,
	output logic                    o_zero,
	output logic                    o_timeout_flag_n,
	output logic                    o_powerdown_flag_n,
	output logic                    o_pin_change_wake_flag,
	output logic                    o_watchdog_counter_clear,
	output logic                    o_prescaler_clear,
	output logic                    o_osc_run,
	output logic [DATA_W-1:0]       o_dir_b,
	output logic [DATA_W-1:0]       o_dir_c
);

	// ****************************************
	// Storage
	// ****************************************
	twx_fr_if fr ();

	twx_file_mem u_mem (
		.i_clk (i_clk),
		.fr    (fr)
	);

	twx_state_t         state;
	twx_state_t         next_state;
	logic [1:0]         phase;
	logic [INSTR_W-1:0] instr;
	logic               wake_meta;
	logic               wake_sync;

	// ****************************************
	// Decode
	// ****************************************
	wire [5:0]        op6       = instr[INSTR_W-1:OP6_LSB];
	wire [3:0]        op4       = instr[INSTR_W-1:OP4_LSB];
	wire [DATA_W-1:0] lit       = instr[DATA_W-1:0];
	wire [ADDR_W-1:0] faddr     = instr[ADDR_W-1:0];
	wire              dest_file = instr[DEST_BIT];
	wire [2:0]        direction_load_op_sel  = instr[DIRECTION_LOAD_OP_SEL_W-1:0];

	wire is_rr     = (op6 == OP6_ROT_RIGHT);
	wire is_rl     = (op6 == OP6_ROT_LEFT);
	wire is_swap   = (op6 == OP6_SWAP);
	wire is_xorf   = (op6 == OP6_XOR_FILE);
	wire is_sub    = (op6 == OP6_SUB);
	wire is_return_with_literal_op  = (op4 == OP4_RET_LIT);
	wire is_xor_literal_op  = (op4 == OP4_XOR_LIT);
	wire is_sleep  = (instr == OP_SLEEP);
	wire is_direction_load_op   = (instr[INSTR_W-1:DIRECTION_LOAD_OP_SEL_W] == OP9_DIRECTION_LOAD_OP);
	wire is_direction_load_op_b = is_direction_load_op && (direction_load_op_sel == DIRECTION_LOAD_OP_SEL_B);
	wire is_direction_load_op_c = is_direction_load_op && (direction_load_op_sel == DIRECTION_LOAD_OP_SEL_C);
	wire is_byte   = is_rr | is_rl | is_swap | is_xorf | is_sub;

	wire running  = (state == TWX_ST_RUN);
	wire do_fetch = running && (phase == PH_FETCH);
	wire do_exec  = running && (phase == PH_EXEC);

	// ****************************************
	// Datapath
	// ****************************************
	wire [DATA_W-1:0] fval    = fr.rdata;
	wire [DATA_W-1:0] rl_res  = {fval[DATA_W-2:0], o_carry};
	wire [DATA_W-1:0] rr_res  = {o_carry, fval[DATA_W-1:1]};
	wire [DATA_W-1:0] sw_res  = {fval[3:0], fval[7:4]};
	wire [DATA_W-1:0] xf_res  = o_w ^ fval;
	wire [DATA_W-1:0] xl_res  = o_w ^ lit;
	wire [DATA_W:0]   sub_ext = {1'b0, fval} - {1'b0, o_w};
	wire [4:0]        sub_low = {1'b0, fval[3:0]} - {1'b0, o_w[3:0]};
	wire [DATA_W-1:0] sub_res = sub_ext[DATA_W-1:0];

	wire [DATA_W-1:0] byte_res = is_rl   ? rl_res :
	                             is_rr   ? rr_res :
	                             is_swap ? sw_res :
	                             is_xorf ? xf_res : sub_res;

	wire byte_zero = (byte_res == '0);
	wire to_file   = do_exec && is_byte && dest_file;
	wire to_w      = do_exec && is_byte && !dest_file;

	// Read address follows the incoming word during fetch so data arrive before execute
	assign fr.addr  = do_fetch ? i_instr[ADDR_W-1:0] : faddr;
	assign fr.wr_en = to_file;
	assign fr.wdata = byte_res;

	// ****************************************
	// Sequencing
	// ****************************************
	wire wake_now = (state == TWX_ST_SLEEP) && wake_sync;

	always_comb begin
		next_state = state;
		case (state)
			TWX_ST_RUN: begin
				if (phase == PH_LAST && is_return_with_literal_op) begin
					next_state = TWX_ST_FLUSH;
				end else if (phase == PH_LAST && is_sleep) begin
					next_state = TWX_ST_SLEEP;
				end
			end
			TWX_ST_FLUSH: begin
				if (phase == PH_LAST) begin
					next_state = TWX_ST_RUN;
				end
			end
			TWX_ST_SLEEP: begin
				if (wake_now) begin
					next_state = TWX_ST_RUN;
				end
			end
			default: begin
				next_state = TWX_ST_RUN;
			end
		endcase
	end

	wire [1:0] next_phase = (state == TWX_ST_SLEEP) ? PH_FETCH : phase + 2'h1;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state <= TWX_ST_RUN;
			phase <= PH_FETCH;
		end else begin
			state <= next_state;
			phase <= next_phase;
		end
	end

	// Pin is asynchronous, second stage alone feeds logic
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
		end else begin
			wake_meta <= i_wake_pin;
			wake_sync <= wake_meta;
		end
	end

	// Word is held for the whole cycle; flush cycle discards its fetch
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			instr <= RST_INSTR;
		end else if (do_fetch) begin
			instr <= i_instr;
		end
	end

	// ****************************************
	// Architectural state
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_w <= RST_W;
		end else if (do_exec && is_return_with_literal_op) begin
			o_w <= lit;
		end else if (do_exec && is_xor_literal_op) begin
			o_w <= xl_res;
		end else if (to_w) begin
			o_w <= byte_res;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_carry            <= 1'b0;
			o_digit_carry_flag <= 1'b0;
			o_zero             <= 1'b0;
		end else if (do_exec) begin
			if (is_rl) begin
				o_carry <= fval[DATA_W-1];
			end else if (is_rr) begin
				o_carry <= fval[0];
			end else if (is_sub) begin
				o_carry            <= ~sub_ext[DATA_W];
				o_digit_carry_flag <= ~sub_low[4];
				o_zero             <= byte_zero;
			end else if (is_xorf) begin
				o_zero <= byte_zero;
			end else if (is_xor_literal_op) begin
				o_zero <= (xl_res == '0);
			end
		end
	end

	// Power flags survive until reset; wake flag is only set by a wake from sleep
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_timeout_flag_n       <= 1'b1;
			o_powerdown_flag_n     <= 1'b1;
			o_pin_change_wake_flag <= 1'b0;
		end else begin
			if (do_exec && is_sleep) begin
				o_timeout_flag_n   <= 1'b1;
				o_powerdown_flag_n <= 1'b0;
			end
			if (wake_now) begin
				o_pin_change_wake_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_watchdog_counter_clear <= 1'b0;
			o_prescaler_clear        <= 1'b0;
		end else begin
			o_watchdog_counter_clear <= do_exec && is_sleep;
			o_prescaler_clear        <= do_exec && is_sleep;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_pc_load  <= 1'b0;
			o_pc_value <= RST_PC;
		end else begin
			o_pc_load <= do_exec && is_return_with_literal_op;
			if (do_exec && is_return_with_literal_op) begin
				o_pc_value <= i_stack_top;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_dir_b <= RST_DIR;
			o_dir_c <= RST_DIR;
		end else if (do_exec) begin
			if (is_direction_load_op_b) begin
				o_dir_b <= o_w;
			end
			if (is_direction_load_op_c) begin
				o_dir_c <= o_w;
			end
		end
	end

	// Strobe marks phase 0 of a running cycle, i.e. when i_instr is taken
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_cycle_strobe <= 1'b1;
			o_osc_run      <= 1'b1;
		end else begin
			o_cycle_strobe <= (next_state == TWX_ST_RUN) && (next_phase == PH_FETCH);
			o_osc_run      <= (next_state != TWX_ST_SLEEP);
		end
	end

endmodule

// ---- tb/twx_exec_properties.sv ----
// Purpose: Port checks for the execute subset.
// Assumes: Results show two edges after the take edge.
// Notes:   File data are unknown, so file ops are judged on flags only.
module twx_exec_properties
	import twx_pkg::*;
(
	input wire logic              i_clk,
	input wire logic              i_nrst,
	input wire logic [INSTR_W-1:0] i_instr,
	input wire logic [PC_W-1:0]   i_stack_top,
	input wire logic              o_cycle_strobe,
	input wire logic [DATA_W-1:0] o_w,
	input wire logic              o_pc_load,
	input wire logic [PC_W-1:0]   o_pc_value,
	input wire logic              o_carry,
	input wire logic              o_zero,
	input wire logic              o_timeout_flag_n,
	input wire logic              o_powerdown_flag_n,
	input wire logic              o_pin_change_wake_flag,
	input wire logic              o_watchdog_counter_clear,
	input wire logic              o_prescaler_clear,
	input wire logic              o_osc_run,
	input wire logic [DATA_W-1:0] o_dir_b,
	input wire logic [DATA_W-1:0] o_dir_c
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Take decode
	// ****************
	wire logic t_ret = o_cycle_strobe && i_instr[11:8] == OP4_RET_LIT;
	wire logic t_xl  = o_cycle_strobe && i_instr[11:8] == OP4_XOR_LIT;
	wire logic t_dir = o_cycle_strobe && i_instr[11:1] == 11'h003;
	wire logic t_slp = o_cycle_strobe && i_instr == OP_SLEEP;
	wire logic t_swp = o_cycle_strobe && i_instr[11:6] == OP6_SWAP;
	wire logic t_rot = o_cycle_strobe && i_instr[11:7] == 5'h06;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	a_cycle_four_clk:
		assert property (o_cycle_strobe && !t_ret && !t_slp |=>
			!o_cycle_strobe [*3] ##1 o_cycle_strobe) else $error("bad cycle length");
	a_ret_two_cyc:
		assert property (t_ret |=> !o_cycle_strobe [*7] ##1 o_cycle_strobe)
		else $error("return not two cycles");
	a_ret_loads:
		assert property (t_ret |-> ##3 o_pc_load && o_w == $past(i_instr[7:0], 3) &&
			o_pc_value == $past(i_stack_top) && $stable(o_zero)) else $error("bad return");
	a_xor_lit:
		assert property (t_xl |-> ##3 o_w == ($past(o_w) ^ $past(i_instr[7:0], 3)) &&
			o_zero == (o_w == 8'h00)) else $error("bad xor literal");
	a_dir_load:
		assert property (t_dir |-> ##3 ($past(i_instr[0], 3) ? o_dir_c : o_dir_b) ==
			$past(o_w) && $stable(o_zero)) else $error("bad direction load");
	a_sleep_flags:
		assert property (t_slp |-> ##3 o_timeout_flag_n && !o_powerdown_flag_n &&
			o_watchdog_counter_clear && o_prescaler_clear && $stable(o_pin_change_wake_flag))
		else $error("bad sleep flags");
	a_sleep_halt:
		assert property (t_slp |-> ##4 !o_osc_run && !o_cycle_strobe) else $error("no halt");
	a_clear_pulse:
		assert property ($rose(o_watchdog_counter_clear) |-> o_prescaler_clear &&
			$past(t_slp, 3) ##1 !o_watchdog_counter_clear) else $error("stray clear");
	a_swap_no_flag:
		assert property (t_swp |-> ##3 $stable(o_carry) && $stable(o_zero))
		else $error("swap moved a flag");
	a_rot_only_c:
		assert property (t_rot |-> ##3 $stable(o_zero)) else $error("rotate moved zero");

	c_ret: cover property (t_ret);
	c_sleep: cover property (t_slp);
	c_wake: cover property ($rose(o_osc_run));
endmodule

bind twx_exec twx_exec_properties twx_exec_properties_inst (.i_clk, .i_nrst, .i_instr,
	.i_stack_top, .o_cycle_strobe, .o_w, .o_pc_load, .o_pc_value, .o_carry, .o_zero,
	.o_timeout_flag_n, .o_powerdown_flag_n, .o_pin_change_wake_flag,
	.o_watchdog_counter_clear, .o_prescaler_clear, .o_osc_run, .o_dir_b, .o_dir_c);

// ---- tb/twx_exec_tb.sv ----
// Purpose: Self-checking bench for the execute subset.
// Assumes: File registers are never reset, so file ops are judged on W and flags.
// Notes:   One take every four clocks except after a return or a sleep, results two edges later.
module twx_exec_tb
	import twx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [11:0] ins;
		logic [10:0] stk;
		logic [7:0]  w;
		logic        z;
		logic        pcl;
		logic [7:0]  db;
		logic [7:0]  dc;
	} twx_row_t;
	logic                i_clk, i_nrst, i_wake_pin;
	logic [INSTR_W-1:0]  i_instr;
	logic [PC_W-1:0]     i_stack_top, o_pc_value;
	logic [DATA_W-1:0]   o_w, o_dir_b, o_dir_c;
	logic                o_cycle_strobe, o_pc_load, o_carry, o_digit_carry_flag, o_zero;
	logic                o_timeout_flag_n, o_powerdown_flag_n, o_pin_change_wake_flag;
	logic                o_watchdog_counter_clear, o_prescaler_clear, o_osc_run;
	int                  bad_count, samples_checked, n;
	twx_row_t            rows [10];

	twx_exec twx_exec_inst (.i_clk, .i_nrst, .i_instr, .i_stack_top, .i_wake_pin,
		.o_cycle_strobe, .o_w, .o_pc_load, .o_pc_value, .o_carry, .o_digit_carry_flag,
		.o_zero, .o_timeout_flag_n, .o_powerdown_flag_n, .o_pin_change_wake_flag,
		.o_watchdog_counter_clear, .o_prescaler_clear, .o_osc_run, .o_dir_b, .o_dir_c);

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask

	// Word is set three edges after the previous take, so it is steady at its own take
	task automatic run(input logic [11:0] ins, input logic [10:0] stk);
		int k;
		k = 0;
		@(posedge i_clk);
		i_instr <= ins;
		i_stack_top <= stk;
		do begin
			@(negedge i_clk);
			k++;
		end while (o_cycle_strobe !== 1'b1 && k < 20);
		repeat (3) @(posedge i_clk);
		#1;
	endtask

	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge i_clk);
		bad_count++;
		$display("BAD t=%0t watchdog expired", $time);
		end_of_test;
	end

	initial begin
		bad_count = 0;
		samples_checked = 0;
		i_nrst = 1'b0;
		i_wake_pin = 1'b0;
		i_instr = 12'h000;
		i_stack_top = 11'h000;
		rows = '{'{12'hFA5, 11'h000, 8'hA5, 1'b0, 1'b0, 8'hFF, 8'hFF},
			'{12'hFA5, 11'h000, 8'h00, 1'b1, 1'b0, 8'hFF, 8'hFF},
			'{12'h006, 11'h000, 8'h00, 1'b1, 1'b0, 8'h00, 8'hFF},
			'{12'hF3C, 11'h000, 8'h3C, 1'b0, 1'b0, 8'h00, 8'hFF},
			'{12'h007, 11'h000, 8'h3C, 1'b0, 1'b0, 8'h00, 8'h3C},
			'{12'h005, 11'h000, 8'h3C, 1'b0, 1'b0, 8'h00, 8'h3C},
			'{12'h881, 11'h7FF, 8'h81, 1'b0, 1'b1, 8'h00, 8'h3C},
			'{12'hF81, 11'h000, 8'h00, 1'b1, 1'b0, 8'h00, 8'h3C},
			'{12'h85A, 11'h000, 8'h5A, 1'b1, 1'b1, 8'h00, 8'h3C},
			'{12'hF5B, 11'h000, 8'h01, 1'b0, 1'b0, 8'h00, 8'h3C}};
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		// ****************
		// Table of literal, direction and return cases
		// ****************
		foreach (rows[i]) begin
			run(rows[i].ins, rows[i].stk);
			chk({o_w, o_zero, o_pc_load}, {rows[i].w, rows[i].z, rows[i].pcl});
			chk({o_dir_b, o_dir_c}, {rows[i].db, rows[i].dc});
			if (rows[i].pcl) chk(o_pc_value, rows[i].stk);
		end
		$display("table done");
		// ****************
		// File ops, written back to file
		// ****************
		run(12'h3A3, 11'h000);
		chk({o_w, o_carry, o_zero}, 10'h004);
		run(12'h363, 11'h000);
		chk(o_zero, 1'b0);
		run(12'h323, 11'h000);
		chk({o_w, o_zero}, 9'h002);
		run(12'h1A3, 11'h000);
		chk(o_w, 8'h01);
		run(12'h0A3, 11'h000);
		chk(o_w, 8'h01);
		$display("file ops done");
		// ****************
		// Sleep, wake, sleep again, reset while asleep
		// ****************
		run(OP_SLEEP, 11'h000);
		chk({o_timeout_flag_n, o_powerdown_flag_n, o_pin_change_wake_flag}, 3'h4);
		chk({o_watchdog_counter_clear, o_prescaler_clear}, 2'h3);
		@(posedge i_clk);
		i_instr <= 12'hF01;
		repeat (8) @(posedge i_clk);
		#1;
		chk({o_osc_run, o_cycle_strobe, o_w}, 10'h001);
		@(posedge i_clk);
		i_instr <= 12'h000;
		i_wake_pin <= 1'b1;
		n = 0;
		while (o_osc_run !== 1'b1 && n < 8) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk({o_osc_run, o_pin_change_wake_flag}, 2'h3);
		@(posedge i_clk);
		i_wake_pin <= 1'b0;
		run(OP_SLEEP, 11'h000);
		chk({o_pin_change_wake_flag, o_powerdown_flag_n}, 2'h2);
		$display("sleep done");
		@(posedge i_clk);
		i_nrst <= 1'b0;
		// Stale sleep word would be taken at the first edge after release
		i_instr <= 12'h000;
		repeat (2) @(posedge i_clk);
		#1;
		chk({o_w, o_dir_b, o_dir_c}, 24'h00_FFFF);
		chk({o_timeout_flag_n, o_powerdown_flag_n, o_pin_change_wake_flag, o_osc_run}, 4'hD);
		chk({o_carry, o_digit_carry_flag, o_zero}, 3'h0);
		@(posedge i_clk);
		i_nrst <= 1'b1;
		run(12'hFFF, 11'h000);
		chk({o_w, o_zero}, 9'h1FE);
		$display("reset done");
		end_of_test;
	end
endmodule
